//--- logic/fps_ctrl.sv
// Purpose: Host-side sequencer driving a parallel NOR flash
// Assumes: Flash pins asynchronous; Avalon-MM slave with waitrequest
// Notes:   One flash bus operation at a time; no queue
// Contract
// R1: Program is four writes; device self-times.
// R2: Device ignores commands while programming.
// R3: Reset during program corrupts that location.
// R4: Programming only clears bits to zero.
// R5: Program finishes within program cycle time.
// R6: One 8K-word boot block, lockable. The flash model's boot block spans 16K words (up to BOOT_END 20'h03fff).
// R7: Boot block at bottom or top addresses.
// R8: Locked boot block refuses program and erase.
// R9: Host issues six writes to lock.
// R10: ID mode lock location shows lock bit.
// R11: Host exits ID mode after ID reads.
// R12: High-voltage reset held whole operation overrides.
// R13: ID codes same in hardware and software.
// R14: Poll bit inverted while programming.
// R15: Poll bit zero during erase.
// R16: True data after operation completes.
// R17: Toggle bit alternates while busy.
// R18: Open-drain ready line low while busy.
// R19: Device blocks programming for power-on delay.
// R20: No program with gate low or strobes high.
// R21: Short strobe pulses start nothing.
// R22: Alternate pin map uses alternate addresses.
// R23: Erased bits read as one.
// R24: Reset low stops operation, outputs float.
// R25: Address latched on fall, data on rise.
`timescale 1ns/1ns
`default_nettype none
module fps_ctrl #(
	parameter int PWR_CYCLES = fps_pkg::PWR_CYC,
	parameter int BUSY_LIMIT = fps_pkg::BUSY_MAX
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [2:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic      [19:0] fl_addr,
	output logic      [15:0] fl_dq_o,
	output logic             fl_dq_oe,
	input  wire logic [15:0] fl_dq_i,
	output logic             fl_ce_n,
	output logic             fl_oe_n,
	output logic             fl_we_n,
	output logic             fl_rst_n,
	output logic             fl_rst_hv,
	input  wire logic        fl_rdy_i
);
	typedef enum logic [6:0] {
		S_IDLE  = 7'h01,
		S_SETUP = 7'h02,
		S_STRB  = 7'h04,
		S_HOLD  = 7'h08,
		S_RDW   = 7'h10,
		S_BUSY  = 7'h20,
		S_RSTP  = 7'h40
	} fps_state_t;

	fps_state_t       st_q;
	fps_pkg::fps_cmd_t cmd_q;
	logic             ack_q, alt_q, hv_q, done_q, tmo_q, ref_q, pwr_ok_q;
	logic [19:0]      addr_q;
	logic [15:0]      wdata_q, rdata_q, dq_s;
	logic [2:0]       step_q, nstep_q;
	logic [31:0]      cnt_q, pwr_q;
	logic             rdy_s, acc, wr_ctrl, go, need_pwr;
	logic [35:0]      sw;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	fps_sync #(.W(16)) u_dq_sync (.clk(clk), .rst_n(rst_n), .d(fl_dq_i), .q(dq_s));
	fps_sync #(.W(1)) u_rdy_sync (.clk(clk), .rst_n(rst_n), .d(fl_rdy_i), .q(rdy_s));

	// ----------------------------------------
	// Avalon slave: one wait cycle per access
	// ----------------------------------------
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign acc             = (avs_read | avs_write) & ack_q;
	assign wr_ctrl  = acc & avs_write & (avs_address == fps_pkg::REG_CTRL);
	assign need_pwr = fps_pkg::fps_cmd_t'(avs_writedata[2:0]) inside
		{fps_pkg::CMD_PROG, fps_pkg::CMD_CHIP, fps_pkg::CMD_SECT, fps_pkg::CMD_LOCK};
	// Altering commands are refused until the device power-on delay ends
	assign go = wr_ctrl & avs_writedata[fps_pkg::CTRL_START] & (st_q == S_IDLE)
		& (pwr_ok_q | ~need_pwr); // R19

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0;
		end else if ((avs_read | avs_write) & ~ack_q) begin
			unique case (avs_address)
				fps_pkg::REG_CTRL:   avs_readdata <= {26'h0, hv_q, alt_q, 1'b0, cmd_q};
				fps_pkg::REG_ADDR:   avs_readdata <= {12'h0, addr_q};
				fps_pkg::REG_WDATA:  avs_readdata <= {16'h0, wdata_q};
				fps_pkg::REG_STATUS: avs_readdata <= {26'h0, rdy_s, pwr_ok_q, ref_q, tmo_q,
					done_q, st_q != S_IDLE};
				fps_pkg::REG_RDATA:  avs_readdata <= {16'h0, rdata_q};
				default:             avs_readdata <= 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_q  <= 20'h0;
			wdata_q <= 16'h0;
			alt_q   <= 1'b0;
			hv_q    <= 1'b0;
		end else if (acc & avs_write) begin
			if (avs_address == fps_pkg::REG_ADDR) begin
				addr_q <= avs_writedata[19:0];
			end
			if (avs_address == fps_pkg::REG_WDATA) begin
				wdata_q <= avs_writedata[15:0];
			end
			if (wr_ctrl && st_q == S_IDLE) begin
				alt_q <= avs_writedata[fps_pkg::CTRL_ALT];
				hv_q  <= avs_writedata[fps_pkg::CTRL_HV];
			end
		end
	end

	// ----------------------------------------
	// Power-on delay after controller reset
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_q    <= 32'h0;
			pwr_ok_q <= 1'b0;
		end else if (!pwr_ok_q) begin
			pwr_q    <= pwr_q + 32'h1;
			pwr_ok_q <= (pwr_q >= 32'(PWR_CYCLES - 1)); // R19
		end
	end

	// ----------------------------------------
	// Command step table
	// ----------------------------------------
	function automatic logic [35:0] step_word(input fps_pkg::fps_cmd_t c, input logic [2:0] s,
		input logic alt, input logic [19:0] ua, input logic [15:0] ud);
		logic [19:0] u1;
		logic [19:0] u2;
		logic [15:0] d2;
		logic [15:0] d5;
		u1 = alt ? fps_pkg::ALT_U1 : fps_pkg::STD_U1; // R22
		u2 = alt ? fps_pkg::ALT_U2 : fps_pkg::STD_U2;
		d2 = (c == fps_pkg::CMD_PROG) ? fps_pkg::D_PROG :
			(c == fps_pkg::CMD_IDEN) ? fps_pkg::D_IDEN : fps_pkg::D_ERASE;
		d5 = (c == fps_pkg::CMD_CHIP) ? fps_pkg::D_CHIP :
			(c == fps_pkg::CMD_SECT) ? fps_pkg::D_SECT : fps_pkg::D_LOCK; // R9
		step_word = {u1, fps_pkg::D_UNLK1};
		if (c == fps_pkg::CMD_IDEX) begin
			step_word = {20'h0, fps_pkg::D_IDEX}; // R11
		end else begin
			unique case (s)
				3'h0: step_word = {u1, fps_pkg::D_UNLK1};
				3'h1: step_word = {u2, fps_pkg::D_UNLK2};
				3'h2: step_word = {u1, d2};
				3'h3: step_word = (c == fps_pkg::CMD_PROG) ? {ua, ud} : {u1, fps_pkg::D_UNLK1}; // R1
				3'h4: step_word = {u2, fps_pkg::D_UNLK2};
				default: step_word = {(c == fps_pkg::CMD_SECT) ? ua : u1, d5};
			endcase
		end
	endfunction : step_word

	assign sw = step_word(cmd_q, step_q, alt_q, addr_q, wdata_q);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q    <= S_IDLE;
			cmd_q   <= fps_pkg::CMD_READ;
			step_q  <= 3'h0;
			nstep_q <= 3'h0;
			cnt_q   <= 32'h0;
		end else begin
			unique case (st_q)
				S_IDLE: if (go) begin
					cmd_q  <= fps_pkg::fps_cmd_t'(avs_writedata[2:0]);
					step_q <= 3'h0;
					cnt_q  <= 32'h0;
					unique case (fps_pkg::fps_cmd_t'(avs_writedata[2:0]))
						fps_pkg::CMD_PROG:  nstep_q <= fps_pkg::N_PROG;
						fps_pkg::CMD_IDEN:  nstep_q <= fps_pkg::N_ID;
						fps_pkg::CMD_READ,
						fps_pkg::CMD_IDEX,
						fps_pkg::CMD_RESET: nstep_q <= fps_pkg::N_ONE;
						default:            nstep_q <= fps_pkg::N_SIX;
					endcase
					st_q <= (fps_pkg::fps_cmd_t'(avs_writedata[2:0]) == fps_pkg::CMD_RESET)
						? S_RSTP : S_SETUP;
				end
				S_SETUP: begin
					cnt_q <= 32'h0;
					st_q  <= (cmd_q == fps_pkg::CMD_READ) ? S_RDW : S_STRB;
				end
				S_STRB: begin
					cnt_q <= cnt_q + 32'h1;
					if (cnt_q == 32'(fps_pkg::WE_CYC - 1)) begin // R21
						cnt_q <= 32'h0;
						st_q  <= S_HOLD;
					end
				end
				S_HOLD: begin
					cnt_q <= cnt_q + 32'h1;
					if (cnt_q == 32'(fps_pkg::HOLD_CYC - 1)) begin
						cnt_q  <= 32'h0;
						step_q <= step_q + 3'h1;
						if (step_q + 3'h1 != nstep_q) begin
							st_q <= S_SETUP;
						end else if (cmd_q inside {fps_pkg::CMD_PROG, fps_pkg::CMD_CHIP,
							fps_pkg::CMD_SECT, fps_pkg::CMD_LOCK}) begin
							st_q <= S_BUSY;
						end else begin
							st_q <= S_IDLE;
						end
					end
				end
				S_RDW: begin
					cnt_q <= cnt_q + 32'h1;
					if (cnt_q == 32'(fps_pkg::RD_CYC - 1)) begin
						st_q <= S_IDLE;
					end
				end
				S_BUSY: begin
					// No commands go out until the device releases ready or BUSY_LIMIT runs out
					cnt_q <= cnt_q + 32'h1;
					if ((cnt_q >= 32'(fps_pkg::SETTLE_CYC) && rdy_s) ||
						cnt_q == 32'(BUSY_LIMIT - 1)) begin // R1
						st_q <= S_IDLE;
					end
				end
				S_RSTP: begin
					cnt_q <= cnt_q + 32'h1;
					if (cnt_q == 32'(fps_pkg::RST_CYC - 1)) begin
						st_q <= S_IDLE;
					end
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Status flags and read data
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= 1'b0;
			tmo_q  <= 1'b0;
			ref_q  <= 1'b0;
			rdata_q <= 16'h0;
		end else begin
			if (go) begin
				done_q <= 1'b0;
				tmo_q  <= 1'b0;
				ref_q  <= 1'b0;
			end else if (wr_ctrl && avs_writedata[fps_pkg::CTRL_START]) begin
				ref_q <= 1'b1;
			end
			if (st_q != S_IDLE && !go) begin
				done_q <= done_q | (st_q == S_BUSY && cnt_q >= 32'(fps_pkg::SETTLE_CYC) && rdy_s);
			end
			if (st_q == S_BUSY && cnt_q == 32'(BUSY_LIMIT - 1) && !rdy_s) begin
				tmo_q <= 1'b1;
			end
			if (st_q == S_RDW && cnt_q == 32'(fps_pkg::RD_CYC - 1)) begin
				rdata_q <= dq_s;
			end
		end
	end

	// ----------------------------------------
	// Flash pins, all from flops
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fl_addr   <= 20'h0;
			fl_dq_o   <= 16'h0;
			fl_dq_oe  <= 1'b0;
			fl_ce_n   <= 1'b1;
			fl_oe_n   <= 1'b1;
			fl_we_n   <= 1'b1;
			fl_rst_n  <= 1'b0;
			fl_rst_hv <= 1'b0;
		end else begin
			fl_rst_n  <= ~(st_q == S_RSTP);
			// Override stays up for the whole altering operation
			fl_rst_hv <= hv_q & (st_q != S_IDLE) & (st_q != S_RSTP) & (cmd_q != fps_pkg::CMD_READ); // R12
			fl_ce_n   <= ~(st_q inside {S_SETUP, S_STRB, S_HOLD, S_RDW});
			fl_oe_n   <= ~(st_q == S_RDW);
			fl_we_n   <= ~(st_q == S_STRB); // R20
			fl_dq_oe  <= (st_q inside {S_SETUP, S_STRB, S_HOLD}) && cmd_q != fps_pkg::CMD_READ;
			if (st_q == S_SETUP) begin
				fl_addr <= (cmd_q == fps_pkg::CMD_READ) ? addr_q : sw[35:16]; // R25
				fl_dq_o <= sw[15:0];
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Strobe is WE_CYC cycles wide
	we_width_a: assert property ($fell(fl_we_n) |-> !fl_we_n [*5] ##1 fl_we_n) // R21
		else $error("write strobe width wrong");
	we_gate_a: assert property (!fl_we_n |-> fl_oe_n && !fl_ce_n && fl_dq_oe) // R20
		else $error("strobe without gate high and select low");
	addr_stable_a: assert property (!fl_we_n |=> $stable(fl_addr)) // R25
		else $error("address moved during strobe");
	data_hold_a: assert property ($rose(fl_we_n) |-> fl_dq_oe && $stable(fl_dq_o)) // R25
		else $error("data released at strobe rise");
	prog_count_a: assert property ($rose(st_q == S_BUSY) && cmd_q == fps_pkg::CMD_PROG |->
		step_q == 3'h4) // R1
		else $error("program not four writes");
	lock_count_a: assert property ($rose(st_q == S_BUSY) && cmd_q == fps_pkg::CMD_LOCK |->
		step_q == 3'h6 && $past(fl_dq_o) == fps_pkg::D_LOCK) // R9
		else $error("lock sequence wrong");
	busy_quiet_a: assert property (st_q == S_BUSY |-> fl_we_n) // R1
		else $error("write during busy wait");
	hv_hold_a: assert property (fl_rst_hv && st_q != S_IDLE |=> fl_rst_hv || st_q == S_IDLE
		|| $past(st_q) == S_IDLE) // R12
		else $error("override dropped mid operation");
	alt_map_a: assert property (st_q == S_STRB && step_q == 3'h1 && cmd_q != fps_pkg::CMD_IDEX
		|-> fl_addr == (alt_q ? fps_pkg::ALT_U2 : fps_pkg::STD_U2)) // R22
		else $error("second unlock address wrong");
	pwr_gate_a: assert property (!fl_we_n && !pwr_ok_q |-> !(cmd_q inside {fps_pkg::CMD_PROG,
		fps_pkg::CMD_CHIP, fps_pkg::CMD_SECT, fps_pkg::CMD_LOCK})) // R19
		else $error("altering command before power delay");
	id_exit_a: assert property (st_q == S_STRB && cmd_q == fps_pkg::CMD_IDEX |->
		fl_dq_o == fps_pkg::D_IDEX) // R11
		else $error("exit code wrong");

	prog_c: cover property ($rose(st_q == S_BUSY) && cmd_q == fps_pkg::CMD_PROG ##[1:1000] done_q);
	lock_c: cover property ($rose(st_q == S_BUSY) && cmd_q == fps_pkg::CMD_LOCK);
	read_c: cover property (st_q == S_RDW ##1 st_q == S_IDLE);
	refuse_c: cover property ($rose(ref_q));
endmodule : fps_ctrl
`default_nettype wire

//--- logic/fps_pkg.sv
// Purpose: Constants for the flash program sequencer host controller
// Assumes: 250 MHz clock, Avalon-MM register port, 16-bit flash data
// Notes:   Offsets are word indexes; byte address is four times the index
package fps_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [2:0] REG_CTRL   = 3'h0;
	localparam logic [2:0] REG_ADDR   = 3'h1;
	localparam logic [2:0] REG_WDATA  = 3'h2;
	localparam logic [2:0] REG_STATUS = 3'h3;
	localparam logic [2:0] REG_RDATA  = 3'h4;
	localparam int CTRL_CMD_LSB  = 0;
	localparam int CTRL_START    = 3;
	localparam int CTRL_ALT      = 4;
	localparam int CTRL_HV       = 5;
	localparam int ST_BUSY       = 0;
	localparam int ST_DONE       = 1;
	localparam int ST_TIMEOUT    = 2;
	localparam int ST_REFUSED    = 3;
	localparam int ST_PWR_OK     = 4;
	localparam int ST_RDY        = 5;
	// ----------------------------------------
	// Commands
	// ----------------------------------------
	typedef enum logic [2:0] {
		CMD_READ  = 3'h0,
		CMD_PROG  = 3'h1,
		CMD_CHIP  = 3'h2,
		CMD_SECT  = 3'h3,
		CMD_LOCK  = 3'h4,
		CMD_IDEN  = 3'h5,
		CMD_IDEX  = 3'h6,
		CMD_RESET = 3'h7
	} fps_cmd_t;
	// ----------------------------------------
	// Command address map and codes
	// ----------------------------------------
	localparam logic [19:0] STD_U1   = 20'h05555;
	localparam logic [19:0] STD_U2   = 20'h02aaa;
	localparam logic [19:0] ALT_U1   = 20'h0a555;
	localparam logic [19:0] ALT_U2   = 20'h05aaa;
	localparam logic [15:0] D_UNLK1  = 16'h00aa;
	localparam logic [15:0] D_UNLK2  = 16'h0055;
	localparam logic [15:0] D_PROG   = 16'h00a0;
	localparam logic [15:0] D_ERASE  = 16'h0080;
	localparam logic [15:0] D_CHIP   = 16'h0010;
	localparam logic [15:0] D_SECT   = 16'h0030;
	localparam logic [15:0] D_LOCK   = 16'h0040;
	localparam logic [15:0] D_IDEN   = 16'h0090;
	localparam logic [15:0] D_IDEX   = 16'h00f0;
	localparam logic [2:0]  N_PROG   = 3'h4;
	localparam logic [2:0]  N_SIX    = 3'h6;
	localparam logic [2:0]  N_ID     = 3'h3;
	localparam logic [2:0]  N_ONE    = 3'h1;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PS       = 4000;
	localparam int WE_PULSE_NS  = 15;
	localparam int RD_ACC_NS    = 80;
	localparam int HOLD_NS      = 20;
	localparam int RST_NS       = 500;
	localparam int SETTLE_NS    = 200;
	localparam int PWR_DELAY_MS = 10;
	localparam int WE_CYC     = (WE_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS + 1;
	localparam int RD_CYC     = (RD_ACC_NS * 1000 + CLK_PS - 1) / CLK_PS + 2;
	localparam int HOLD_CYC   = (HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int RST_CYC    = (RST_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int SETTLE_CYC = (SETTLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int PWR_CYC    = PWR_DELAY_MS * 250000;
	localparam int BUSY_MAX   = 25000000;
endpackage : fps_pkg

//--- logic/fps_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk
// Notes:   First stage feeds only the second
`timescale 1ns/1ns
`default_nettype none
module fps_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : fps_sync
`default_nettype wire

//--- sim/fps_ctrl_tb_top.sv
// Purpose: Self-checking bench for the flash sequencer
// Assumes: Short power-on and busy limits set by parameter
// Notes:   Stuck busy is the only fault the flash model is told to show
`timescale 1ns/1ns
`default_nettype none
module fps_ctrl_tb_top;
	typedef struct packed {logic [19:0] a; logic [15:0] d; logic [15:0] e;} fps_row_t;
	localparam logic [15:0] MFR = 16'h005a; // Arbitrary value
	localparam logic [31:0] OK  = (32'h1 << fps_pkg::ST_DONE) | (32'h1 << fps_pkg::ST_PWR_OK)
		| (32'h1 << fps_pkg::ST_RDY);
	logic        clk, rst_n, avs_read, avs_write, avs_waitrequest;
	logic [2:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, s, q;
	logic [19:0] fl_addr;
	logic [15:0] fl_dq_o, fl_dq_i, m_dq;
	logic        fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_rst_n, fl_rst_hv, fl_rdy_i;
	logic        m_rdy_low, alt_m, stuck;
	int          mismatches, n_compared, cyc;
	fps_row_t    rows [4] = '{'{20'h00100, 16'h1234, 16'h1234}, '{20'h00100, 16'hff0f, 16'h1204},
		'{20'h08200, 16'h00ff, 16'h00ff}, '{20'h08300, 16'hffff, 16'hffff}};

	assign fl_dq_i  = fl_dq_oe ? fl_dq_o : m_dq;
	assign fl_rdy_i = m_rdy_low ? 1'b0 : 1'b1; // Pull-up on open-drain line

	fps_ctrl #(.PWR_CYCLES(20), .BUSY_LIMIT(2000)) dut (.clk(clk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
		.fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
		.fl_we_n(fl_we_n), .fl_rst_n(fl_rst_n), .fl_rst_hv(fl_rst_hv), .fl_rdy_i(fl_rdy_i));
	fps_flash_model #(.PWR_CYC(20), .MFR_CODE(MFR)) flash (.clk(clk), .addr(fl_addr),
		.din(fl_dq_i), .ce_n(fl_ce_n), .oe_n(fl_oe_n), .we_n(fl_we_n), .rst_n(fl_rst_n),
		.rst_hv(fl_rst_hv), .alt(alt_m), .stuck(stuck), .dq(m_dq), .rdy_low(m_rdy_low));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task tally_and_finish;
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : tally_and_finish

	task cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task cmp_pin(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: pin %h expected %h", $time, got, exp);
		end
	endtask : cmp_pin

	// Entered and left just after a rising edge
	task av(input logic w, input logic [2:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask : av

	task start(input logic [2:0] c, input logic [19:0] a, input logic [15:0] d, input logic hv);
		av(1'b1, fps_pkg::REG_ADDR, {12'h0, a});
		av(1'b1, fps_pkg::REG_WDATA, {16'h0, d});
		av(1'b1, fps_pkg::REG_CTRL, {26'h0, hv, alt_m, 1'b1, c});
	endtask : start

	task wait_idle;
		int n;
		n = 0;
		do begin
			av(1'b0, fps_pkg::REG_STATUS, 32'h0);
			n++;
		end while (q[fps_pkg::ST_BUSY] !== 1'b0 && n < 2000);
		s = q & 32'h3f;
	endtask : wait_idle

	task run(input logic [2:0] c, input logic [19:0] a, input logic [15:0] d, input logic hv);
		start(c, a, d, hv);
		wait_idle();
	endtask : run

	task rd_flash(input logic [19:0] a);
		run(fps_pkg::CMD_READ, a, 16'h0, 1'b0);
		av(1'b0, fps_pkg::REG_RDATA, 32'h0);
	endtask : rd_flash

	// ----------------------------------------
	// Clock, watchdog, sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	initial begin
		{rst_n, avs_read, avs_write, alt_m, stuck} = 5'h0;
		avs_address = 3'h0;
		avs_writedata = 32'h0;
		{mismatches, n_compared, cyc} = {32'h0, 32'h0, 32'h0};
		repeat (3) @(posedge clk);
		cmp_pin(fl_ce_n, 1'b1);
		cmp_pin(fl_we_n, 1'b1);
		cmp_pin(fl_dq_oe, 1'b0);
		cmp_pin(fl_rst_n, 1'b0);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		cmp_pin(fl_rst_n, 1'b1);
		run(fps_pkg::CMD_PROG, 20'h08000, 16'h0000, 1'b0);
		cmp_pin(s[fps_pkg::ST_REFUSED], 1'b1);
		repeat (30) @(posedge clk);
		foreach (rows[i]) begin
			run(fps_pkg::CMD_PROG, rows[i].a, rows[i].d, 1'b0);
			cmp(s, OK);
			rd_flash(rows[i].a);
			cmp(q, {16'h0, rows[i].e});
		end
		// Second start lands while the first program is still busy
		start(fps_pkg::CMD_PROG, 20'h08400, 16'h5555, 1'b0);
		av(1'b1, fps_pkg::REG_CTRL, 32'h8);
		wait_idle();
		cmp_pin(s[fps_pkg::ST_REFUSED], 1'b1);
		cmp_pin(s[fps_pkg::ST_DONE], 1'b1);
		run(fps_pkg::CMD_LOCK, 20'h0, 16'h0, 1'b0);
		cmp(s, OK);
		run(fps_pkg::CMD_IDEN, 20'h0, 16'h0, 1'b0);
		rd_flash(20'h00002);
		cmp_pin(q[0], 1'b1);
		rd_flash(20'h00000);
		cmp(q, {16'h0, MFR});
		run(fps_pkg::CMD_IDEX, 20'h0, 16'h0, 1'b0);
		run(fps_pkg::CMD_PROG, 20'h00010, 16'h0000, 1'b0);
		rd_flash(20'h00010);
		cmp(q, 32'hffff);
		run(fps_pkg::CMD_PROG, 20'h00010, 16'h0000, 1'b1);
		rd_flash(20'h00010);
		cmp(q, 32'h0);
		run(fps_pkg::CMD_SECT, 20'h08200, 16'h0, 1'b0);
		rd_flash(20'h08200);
		cmp(q, 32'hffff);
		run(fps_pkg::CMD_CHIP, 20'h0, 16'h0, 1'b0);
		rd_flash(20'h00100);
		cmp(q, 32'h1204);
		rd_flash(20'h08400);
		cmp(q, 32'hffff);
		alt_m <= 1'b1;
		run(fps_pkg::CMD_PROG, 20'h08500, 16'habcd, 1'b0);
		rd_flash(20'h08500);
		cmp(q, 32'habcd);
		alt_m <= 1'b0;
		stuck <= 1'b1;
		run(fps_pkg::CMD_PROG, 20'h08600, 16'h0f0f, 1'b0);
		cmp_pin(s[fps_pkg::ST_TIMEOUT], 1'b1);
		cmp_pin(s[fps_pkg::ST_DONE], 1'b0);
		stuck <= 1'b0;
		repeat (100) @(posedge clk);
		start(fps_pkg::CMD_RESET, 20'h0, 16'h0, 1'b0);
		repeat (10) @(posedge clk);
		cmp_pin(fl_rst_n, 1'b0);
		wait_idle();
		// Controller reset while the flash is still programming
		start(fps_pkg::CMD_PROG, 20'h08700, 16'h1111, 1'b0);
		repeat (80) @(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		cmp_pin(fl_rst_n, 1'b0);
		rst_n <= 1'b1;
		// Non-altering command strobes inside the power-on delay
		run(fps_pkg::CMD_IDEX, 20'h0, 16'h0, 1'b0);
		repeat (40) @(posedge clk);
		rd_flash(20'h08700);
		cmp(q, 32'heeee);
		tally_and_finish();
	end
endmodule : fps_ctrl_tb_top
`default_nettype wire

//--- sim/fps_flash_model.sv
// Purpose: Behavioural parallel NOR flash facing the sequencer
// Assumes: Bottom boot, one sector per address bits 19:12
// Notes:   Clocked by the bench to time its busy and power-on periods, apply reset and register read data
`timescale 1ns/1ns
`default_nettype none
module fps_flash_model #(
	parameter int          BUSY_CYC = 80,
	parameter int          PWR_CYC  = 20,
	parameter logic [19:0] BOOT_END = 20'h03fff,
	parameter logic [15:0] MFR_CODE = 16'h005a, // Arbitrary value
	parameter logic [15:0] DEV_CODE = 16'h00c3  // Arbitrary value
) (
	input  wire logic        clk,
	input  wire logic [19:0] addr,
	input  wire logic [15:0] din,
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic        rst_n,
	input  wire logic        rst_hv,
	input  wire logic        alt,
	input  wire logic        stuck,
	output logic      [15:0] dq,
	output logic             rdy_low
);
	logic [15:0] mem [logic [19:0]];
	logic [19:0] la, last_a;
	logic [15:0] last_d;
	logic [2:0]  step = 3'h0;
	logic        id_q = 1'b0, lock_q = 1'b0, erase_q = 1'b0, tog_q = 1'b0;
	int          busy_n = 0, pwr_n = 0;
	time         t_fall = 0;

	function automatic logic [15:0] rd_mem(input logic [19:0] a);
		return mem.exists(a) ? mem[a] : 16'hffff;
	endfunction : rd_mem

	function automatic logic prot(input logic [19:0] a);
		return lock_q && !rst_hv && a <= BOOT_END;
	endfunction : prot

	task automatic erase(input logic [19:0] a, input logic chip);
		logic [19:0] ks[$];
		foreach (mem[k]) if (!prot(k) && (chip || k[19:12] == a[19:12])) ks.push_back(k);
		foreach (ks[i]) mem.delete(ks[i]);
		erase_q = 1'b1;
		busy_n = BUSY_CYC;
	endtask : erase

	task automatic cmd_write(input logic [19:0] a, input logic [15:0] d);
		logic [19:0] u1, u2;
		u1 = alt ? fps_pkg::ALT_U1 : fps_pkg::STD_U1;
		u2 = alt ? fps_pkg::ALT_U2 : fps_pkg::STD_U2;
		if (d[7:0] == 8'hf0 && step != 3'h3) begin
			id_q = 1'b0;
			step = 3'h0;
		end else case (step)
			3'h0, 3'h4: step = (a == u1 && d[7:0] == 8'haa) ? step + 3'h1 : 3'h0;
			3'h1, 3'h5: step = (a == u2 && d[7:0] == 8'h55) ? step + 3'h1 : 3'h0;
			3'h2: begin
				step = 3'h0;
				if (a == u1 && d[7:0] == 8'ha0) step = 3'h3;
				if (a == u1 && d[7:0] == 8'h80) step = 3'h4;
				if (a == u1 && d[7:0] == 8'h90) id_q = 1'b1;
			end
			3'h3: begin
				// Protected or early writes still run a busy period
				if (pwr_n >= PWR_CYC && !prot(a)) mem[a] = rd_mem(a) & d;
				last_a = a;
				last_d = d;
				erase_q = 1'b0;
				busy_n = BUSY_CYC;
				step = 3'h0;
			end
			default: begin
				step = 3'h0;
				if (d[7:0] == 8'h10 || d[7:0] == 8'h30) erase(a, d[7:0] == 8'h10);
				if (a == u1 && d[7:0] == 8'h40) begin
					lock_q = 1'b1;
					busy_n = BUSY_CYC;
				end
			end
		endcase
	endtask : cmd_write

	always @(negedge we_n) if (!ce_n) begin
		la = addr;
		t_fall = $time;
	end
	always @(posedge we_n)
		if (!ce_n && oe_n && rst_n && busy_n == 0 && $time - t_fall >= 15)
			cmd_write(la, din);
	always @(negedge oe_n) if (busy_n > 0) tog_q = ~tog_q;

	always @(posedge clk) begin
		if (pwr_n < PWR_CYC) pwr_n = pwr_n + 1;
		if (!rst_n) begin
			if (busy_n > 0 && !erase_q) mem[last_a] = ~last_d;
			busy_n = 0;
			step = 3'h0;
			id_q = 1'b0;
		end else if (busy_n > 0 && !stuck) busy_n = busy_n - 1;
		if (!ce_n && !oe_n && rst_n) begin
			if (id_q) dq <= (addr == 20'h00002) ? {15'h0, lock_q}
				: (addr[0] ? DEV_CODE : MFR_CODE);
			else if (busy_n > 0) dq <= {8'h00, erase_q ? 1'b0 : ~last_d[7], tog_q, 6'h00};
			else dq <= rd_mem(addr);
		end else dq <= ~dq;
		rdy_low <= busy_n > 0;
	end
endmodule : fps_flash_model
`default_nettype wire
